// ---- logic/freefall_motion_detector.sv ----
// Operation
// [RL1] freefall mode: flag only when every enabled axis is low-g
// [RL2] motion mode: flag when any enabled axis is high-g
// [RL3] common threshold at 0x17, per-axis thresholds at 0x73 to 0x78
// [RL4] latched mode holds the flag until the source register is read
// [RL5] unlatched mode: flag follows detection sample by sample
// [RL6] debounce mode bit in common threshold register picks filter behaviour
// [RL7] only axes with their enable bit set take part
// [RL8] per-axis enable 0: all axes use the 7-bit common threshold
// [RL9] per-axis enable 1: each axis uses its own 13-bit threshold
// [RL10] latched flag freezes axis flags until the source is read
// [RL11] enabled axis raises its flag beyond threshold, disabled detects nothing
// [RL12] debounce mode 1 clears counter, mode 0 decrements per sample
// [RL13] axis event and polarity bits read zero when axis disabled
// [RL14] flag, interrupt enable and routing bit form the interrupt
// [RL15] common threshold step is 63 mg per lsb
// [RL16] evaluation once per new sample on axis magnitudes
// [RL17] reset clears debounce counter and all event flags
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module freefall_motion_detector
    import fall_motion_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic [7:0]          addr_in,
    input  wire logic [7:0]          wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic [7:0]               rdata_out,
    input  wire logic                sample_valid_in,
    input  wire logic [SAMPLE_W-1:0] accel_x_in,
    input  wire logic [SAMPLE_W-1:0] accel_y_in,
    input  wire logic [SAMPLE_W-1:0] accel_z_in,
    output logic                     event_active_out,
    output logic                     int1_out,
    output logic                     int2_out
);
    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]                     cfg;
        logic [7:0]                     ths;
        logic [7:0]                     count;
        logic [7:0]                     int_ctrl;
        logic [NUM_AXES-1:0][7:0]       thr_msb;
        logic [NUM_AXES-1:0][7:0]       thr_lsb;
        logic [NUM_AXES-1:0]            ev_raw;
        logic [NUM_AXES-1:0]            pol_raw;
        logic                           sample;
        logic                           ea;
        logic [NUM_AXES-1:0]            ev;
        logic [NUM_AXES-1:0]            pol;
        logic [7:0]                     rdata;
    } main_state_t;

    main_state_t s_q;
    main_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // decoded controls

    logic                          latch_en;
    logic                          motion_mode;
    logic [NUM_AXES-1:0]           axis_en;
    logic                          xyz_en;
    logic                          rd_src;
    logic [NUM_AXES-1:0][SAMPLE_W-1:0] accel;
    logic [NUM_AXES-1:0][THR_W-1:0]    thr;
    logic [NUM_AXES-1:0]           high;
    logic [NUM_AXES-1:0]           low;
    logic [NUM_AXES-1:0]           neg;
    logic [NUM_AXES-1:0]           axis_ev;
    logic                          cond;
    logic                          db_active;
    logic [7:0]                    db_count;
    logic [7:0]                    src_word;

    // config field pick-off
    always_comb begin
        latch_en    = s_q.cfg[CFG_LATCH];
        motion_mode = s_q.cfg[CFG_MOTION];
        axis_en     = s_q.cfg[CFG_EN_LSB +: NUM_AXES]; // RL7
        // the enable lives only in the x msb register
        xyz_en      = s_q.thr_msb[0][THR_OWN_EN];
        rd_src      = rd_in && (addr_in == ADDR_SRC);
    end

    // axis order x, y, z on index 0, 1, 2
    assign accel = {accel_z_in, accel_y_in, accel_x_in};

    ////////////////////////////////////////////////////////////////////////
    // per-axis threshold compare

    genvar gi;
    generate
        for (gi = 0; gi < NUM_AXES; gi++) begin : g_axis
            // common value is 63 mg steps, moved onto the fine scale
            always_comb begin
                if (xyz_en) begin
                    thr[gi] = {s_q.thr_msb[gi][COMMON_W-1:0],
                               s_q.thr_lsb[gi][THR_LSB_W-1:0]}; // RL9
                end else begin
                    thr[gi] = {s_q.ths[COMMON_W-1:0],
                               {COMMON_SHIFT{1'b0}}}; // RL8 RL15
                end
            end

            fall_motion_axis u_axis (
                .sample_in (accel[gi]),
                .thr_in    (thr[gi]),
                .high_out  (high[gi]),
                .low_out   (low[gi]),
                .neg_out   (neg[gi])
            );

            // disabled axis never raises its own event
            assign axis_ev[gi] = axis_en[gi] &&
                (motion_mode ? high[gi] : low[gi]); // RL11
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // combine axes

    // no axes enabled means no freefall: an empty and would always fire
    always_comb begin
        if (motion_mode) begin
            cond = |axis_ev; // RL2
        end else begin
            cond = (axis_en != '0) && (axis_ev == axis_en); // RL1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debounce filter

    fall_motion_debounce u_debounce (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .sample_in     (sample_valid_in), // RL16
        .cond_in       (cond),
        .clear_mode_in (s_q.ths[THS_CLR_MODE]), // RL6
        .limit_in      (s_q.count),
        .active_out    (db_active),
        .count_out     (db_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // source word

    // disabled axes read as zero even if stale flags remain inside
    always_comb begin
        src_word = 8'h00;
        src_word[SRC_EA] = s_q.ea;
        for (int i = 0; i < NUM_AXES; i++) begin
            src_word[2*i+1] = s_q.ev[i] & axis_en[i]; // RL13
            src_word[2*i]   = s_q.pol[i] & axis_en[i]; // RL13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        // capture axis results next to the debounce update
        s_d.sample = sample_valid_in;
        if (sample_valid_in) begin
            s_d.ev_raw  = axis_ev;
            s_d.pol_raw = neg & axis_ev;
        end

        // register writes; source register is read-only
        if (wr_in) begin
            case (addr_in)
                ADDR_CFG:      s_d.cfg      = wdata_in;
                ADDR_THS:      s_d.ths      = wdata_in; // RL3
                ADDR_COUNT:    s_d.count    = wdata_in;
                ADDR_INT_CTRL: s_d.int_ctrl = wdata_in;
                default: begin
                    for (int i = 0; i < NUM_AXES; i++) begin
                        if (addr_in == ADDR_THR_BASE + 8'(2*i)) begin
                            s_d.thr_msb[i] = wdata_in; // RL3
                        end
                        if (addr_in == ADDR_THR_BASE + 8'(2*i+1)) begin
                            s_d.thr_lsb[i] = wdata_in; // RL3
                        end
                    end
                end
            endcase
        end

        // reading the source releases a latched event
        if (rd_src && latch_en) begin
            s_d.ea = 1'b0; // RL4
        end

        // evaluated after the clear so a fresh event wins over the read
        if (s_q.sample) begin
            if (!latch_en) begin
                s_d.ea  = db_active; // RL5
                s_d.ev  = s_q.ev_raw;
                s_d.pol = s_q.pol_raw;
            end else if (!s_q.ea || rd_src) begin
                // flags track until the latch closes, then freeze
                s_d.ev  = s_q.ev_raw; // RL10
                s_d.pol = s_q.pol_raw;
                if (db_active) begin
                    s_d.ea = 1'b1; // RL4
                end
            end
        end

        // read data stands the cycle after the strobe only
        s_d.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                ADDR_CFG:      s_d.rdata = s_q.cfg;
                ADDR_SRC:      s_d.rdata = src_word;
                ADDR_THS:      s_d.rdata = s_q.ths;
                ADDR_COUNT:    s_d.rdata = s_q.count;
                ADDR_INT_CTRL: s_d.rdata = s_q.int_ctrl;
                default: begin
                    for (int i = 0; i < NUM_AXES; i++) begin
                        if (addr_in == ADDR_THR_BASE + 8'(2*i)) begin
                            s_d.rdata = s_q.thr_msb[i];
                        end
                        if (addr_in == ADDR_THR_BASE + 8'(2*i+1)) begin
                            s_d.rdata = s_q.thr_lsb[i];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q          <= '0; // RL17
            s_q.cfg      <= CFG_RST;
            s_q.ths      <= THS_RST;
            s_q.count    <= COUNT_RST;
            s_q.int_ctrl <= INT_CTRL_RST;
            s_q.thr_msb  <= {NUM_AXES{THR_RST}};
            s_q.thr_lsb  <= {NUM_AXES{THR_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // interrupt pins are gated from flops, so they glitch-free follow ea
    assign rdata_out        = s_q.rdata;
    assign event_active_out = s_q.ea;
    assign int1_out = s_q.ea && s_q.int_ctrl[INT_EN_BIT] &&
                      s_q.int_ctrl[INT_ROUTE_BIT]; // RL14
    assign int2_out = s_q.ea && s_q.int_ctrl[INT_EN_BIT] &&
                      !s_q.int_ctrl[INT_ROUTE_BIT]; // RL14

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_and_mode;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && !motion_mode && !(&(low | ~axis_en))
        |-> !cond;
    endproperty
    a_and_mode: assert property (p_and_mode) // RL1
        else $error("freefall fired with an enabled axis high");

    property p_or_mode;
        @(posedge clk_in) disable iff (rst_in)
        sample_valid_in && motion_mode && |(high & axis_en) |-> cond;
    endproperty
    a_or_mode: assert property (p_or_mode) // RL2
        else $error("motion missed an enabled high axis");

    property p_real_time;
        @(posedge clk_in) disable iff (rst_in)
        s_q.sample && !latch_en && !wr_in |=> s_q.ea == $past(db_active);
    endproperty
    a_real_time: assert property (p_real_time) // RL5
        else $error("unlatched flag does not follow detection");

    property p_latch_hold;
        @(posedge clk_in) disable iff (rst_in)
        latch_en && s_q.ea && !rd_src && !wr_in |=> s_q.ea;
    endproperty
    a_latch_hold: assert property (p_latch_hold) // RL4
        else $error("latched flag dropped without a source read");

    property p_read_clear;
        @(posedge clk_in) disable iff (rst_in)
        latch_en && s_q.ea && rd_src && !(s_q.sample && db_active)
        |=> !s_q.ea;
    endproperty
    a_read_clear: assert property (p_read_clear) // RL4
        else $error("source read did not clear latched flag");

    property p_freeze;
        @(posedge clk_in) disable iff (rst_in)
        latch_en && s_q.ea && !rd_src && !wr_in
        |=> $stable(s_q.ev) && $stable(s_q.pol);
    endproperty
    a_freeze: assert property (p_freeze) // RL10
        else $error("axis flags moved while latched");

    property p_mask;
        @(posedge clk_in) disable iff (rst_in)
        rd_src ##1 !wr_in |-> (rdata_out[5:0] & ~{{2{$past(axis_en[2])}},
            {2{$past(axis_en[1])}}, {2{$past(axis_en[0])}}}) == 6'h00;
    endproperty
    a_mask: assert property (p_mask) // RL13
        else $error("disabled axis flags read nonzero");

    property p_int_route;
        @(posedge clk_in) disable iff (rst_in)
        s_q.ea && s_q.int_ctrl[INT_EN_BIT] |-> int1_out != int2_out;
    endproperty
    a_int_route: assert property (p_int_route) // RL14
        else $error("interrupt not routed to exactly one pin");

    // a source read in the same cycle must not beat a fresh event
    property p_latch_set;
        @(posedge clk_in) disable iff (rst_in)
        latch_en && s_q.sample && db_active |=> s_q.ea;
    endproperty
    a_latch_set: assert property (p_latch_set) // RL4
        else $error("latched event did not set the flag");

    // between samples the unlatched flag has nothing new to show
    property p_eval_only;
        @(posedge clk_in) disable iff (rst_in)
        !s_q.sample && !latch_en |=> $stable(s_q.ea);
    endproperty
    a_eval_only: assert property (p_eval_only) // RL16
        else $error("unlatched flag moved without a sample");

    property p_flags_track;
        @(posedge clk_in) disable iff (rst_in)
        s_q.sample && !latch_en |=> s_q.ev == $past(s_q.ev_raw) &&
            s_q.pol == $past(s_q.pol_raw);
    endproperty
    a_flags_track: assert property (p_flags_track) // RL5
        else $error("unlatched axis flags did not follow the sample");
endmodule
`default_nettype wire

// ---- logic/fall_motion_pkg.sv ----
`default_nettype none
package fall_motion_pkg;
    // register map, byte addresses on the plain port
    localparam logic [7:0] ADDR_CFG      = 8'h15;
    localparam logic [7:0] ADDR_SRC      = 8'h16;
    localparam logic [7:0] ADDR_THS      = 8'h17;
    localparam logic [7:0] ADDR_COUNT    = 8'h18;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h19;
    localparam logic [7:0] ADDR_THR_BASE = 8'h73;
    // configuration fields
    localparam int CFG_LATCH   = 7;
    localparam int CFG_MOTION  = 6;
    localparam int CFG_EN_LSB  = 3;
    // common threshold fields
    localparam int THS_CLR_MODE = 7;
    // per-axis threshold msb register: enable bit
    localparam int THR_OWN_EN  = 7;
    // source register fields
    localparam int SRC_EA      = 7;
    // interrupt control fields
    localparam int INT_EN_BIT    = 0;
    localparam int INT_ROUTE_BIT = 1;
    // reset values
    localparam logic [7:0] CFG_RST      = 8'h00;
    localparam logic [7:0] THS_RST      = 8'h00;
    localparam logic [7:0] COUNT_RST    = 8'h00;
    localparam logic [7:0] THR_RST      = 8'h00;
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    // data widths
    localparam int NUM_AXES     = 3;
    localparam int SAMPLE_W     = 14;
    localparam int THR_W        = 13;
    localparam int COMMON_W     = 7;
    // common 7-bit threshold sits on the top bits of the 13-bit scale
    localparam int COMMON_SHIFT = THR_W - COMMON_W;
    // low-byte threshold field width
    localparam int THR_LSB_W    = 6;
endpackage
`default_nettype wire

// ---- logic/fall_motion_axis.sv ----
`timescale 1ns/1ns
`default_nettype none
module fall_motion_axis
    import fall_motion_pkg::*;
(
    input  wire logic [SAMPLE_W-1:0] sample_in,
    input  wire logic [THR_W-1:0]    thr_in,
    output logic                     high_out,
    output logic                     low_out,
    output logic                     neg_out
);
    logic [SAMPLE_W-1:0] mag;

    // two's complement magnitude; full negative scale still fits unsigned
    always_comb begin
        neg_out = sample_in[SAMPLE_W-1];
        mag     = neg_out ? (~sample_in + 14'h0001) : sample_in;
    end

    // drop the lsb so magnitude lands on the 13-bit threshold scale
    always_comb begin
        high_out = mag[SAMPLE_W-1:1] > thr_in;
        low_out  = ~high_out;
    end
endmodule
`default_nettype wire

// ---- logic/fall_motion_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
module fall_motion_debounce
    import fall_motion_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       sample_in,
    input  wire logic       cond_in,
    input  wire logic       clear_mode_in,
    input  wire logic [7:0] limit_in,
    output logic            active_out,
    output logic [7:0]      count_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       active;
    } deb_state_t;

    deb_state_t s_q;
    deb_state_t s_d;

    // count up while the condition holds, otherwise clear or bleed down
    always_comb begin
        s_d = s_q;
        if (sample_in) begin
            if (cond_in) begin
                if (s_q.cnt < limit_in) begin
                    s_d.cnt = s_q.cnt + 8'h01;
                end
            end else if (clear_mode_in) begin
                s_d.cnt = 8'h00; // RL12
            end else if (s_q.cnt != 8'h00) begin
                s_d.cnt = s_q.cnt - 8'h01; // RL12
            end
            // limit of zero makes the filter transparent
            s_d.active = cond_in && (s_d.cnt >= limit_in);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0; // RL17
        end else begin
            s_q <= s_d;
        end
    end

    assign active_out = s_q.active;
    assign count_out  = s_q.cnt;

    property p_deb_clear;
        @(posedge clk_in) disable iff (rst_in)
        sample_in && clear_mode_in && !cond_in |=> s_q.cnt == 8'h00;
    endproperty
    a_deb_clear: assert property (p_deb_clear) // RL12
        else $error("debounce count not cleared");

    property p_deb_dec;
        @(posedge clk_in) disable iff (rst_in)
        sample_in && !clear_mode_in && !cond_in && s_q.cnt != 8'h00
        |=> s_q.cnt == $past(s_q.cnt) - 8'h01;
    endproperty
    a_deb_dec: assert property (p_deb_dec) // RL12
        else $error("debounce count not decremented by one");
endmodule
`default_nettype wire

// ---- testbench/freefall_motion_detector_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g))
module freefall_motion_detector_tb_top
    import fall_motion_pkg::*;
;
    logic                clk_in;
    logic                rst_in;
    logic [7:0]          addr_in;
    logic [7:0]          wdata_in;
    logic                wr_in;
    logic                rd_in;
    logic [7:0]          rdata_out;
    logic                sample_valid_in;
    logic [SAMPLE_W-1:0] accel_x_in;
    logic [SAMPLE_W-1:0] accel_y_in;
    logic [SAMPLE_W-1:0] accel_z_in;
    logic                event_active_out;
    logic                int1_out;
    logic                int2_out;
    int                  n_mismatch;
    int                  check_count;

    freefall_motion_detector u_freefall_motion_detector (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .addr_in          (addr_in),
        .wdata_in         (wdata_in),
        .wr_in            (wr_in),
        .rd_in            (rd_in),
        .rdata_out        (rdata_out),
        .sample_valid_in  (sample_valid_in),
        .accel_x_in       (accel_x_in),
        .accel_y_in       (accel_y_in),
        .accel_z_in       (accel_z_in),
        .event_active_out (event_active_out),
        .int1_out         (int1_out),
        .int2_out         (int2_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock, 8 ns period
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one-cycle write strobe, released at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe, so look then
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        `CHK(nm, e, rdata_out);
    endtask

    // flag settles two edges after the strobe edge; two spare edges of margin
    task automatic smp(input logic [13:0] x, input logic [13:0] y,
                       input logic [13:0] z);
        @(posedge clk_in);
        accel_x_in      <= x;
        accel_y_in      <= y;
        accel_z_in      <= z;
        sample_valid_in <= 1'b1;
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rchk("cfg", ADDR_CFG, CFG_RST);
        rchk("ths", ADDR_THS, THS_RST);
        rchk("count", ADDR_COUNT, COUNT_RST);
        rchk("int_ctrl", ADDR_INT_CTRL, INT_CTRL_RST);
        rchk("thr_x_msb", ADDR_THR_BASE, THR_RST);
        rchk("src", ADDR_SRC, 8'h00);
        rchk("unmapped", 8'h20, 8'h00);
        `CHK("ea", 1'b0, event_active_out);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(ADDR_CFG, 8'hF8);
        rchk("cfg", ADDR_CFG, 8'hF8);
        wr(ADDR_SRC, 8'h55);
        rchk("src", ADDR_SRC, 8'h00);
        wr(8'h78, 8'hC5);
        rchk("thr_z_lsb", 8'h78, 8'hC5);
        wr(8'h78, 8'h00);
        wr(ADDR_CFG, 8'h00);
        $display("test regs done");
    endtask

    // motion, x only, common threshold 64 on the 13-bit threshold scale
    task automatic t_motion();
        wr(ADDR_THS, 8'h01);
        wr(ADDR_CFG, 8'h48);
        smp(14'h0200, 14'h0000, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        rchk("src", ADDR_SRC, 8'h82);
        smp(14'h3E00, 14'h0000, 14'h0000);
        rchk("src", ADDR_SRC, 8'h83);
        wr(ADDR_CFG, 8'h40);
        rchk("src", ADDR_SRC, 8'h80);
        wr(ADDR_CFG, 8'h48);
        smp(14'h0000, 14'h0200, 14'h0200);
        `CHK("ea", 1'b0, event_active_out);
        rchk("src", ADDR_SRC, 8'h00);
        smp(14'h0082, 14'h0000, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        smp(14'h0081, 14'h0000, 14'h0000);
        `CHK("ea", 1'b0, event_active_out);
        $display("test motion done");
    endtask

    // freefall, x and y enabled; z large but disabled
    task automatic t_freefall();
        wr(ADDR_CFG, 8'h18);
        smp(14'h0000, 14'h0200, 14'h0000);
        `CHK("ea", 1'b0, event_active_out);
        smp(14'h0000, 14'h0000, 14'h0200);
        `CHK("ea", 1'b1, event_active_out);
        smp(14'h0080, 14'h0080, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        smp(14'h0082, 14'h0000, 14'h0000);
        `CHK("ea", 1'b0, event_active_out);
        $display("test freefall done");
    endtask

    // latched motion with x and y, interrupt routing along the way
    task automatic t_latch();
        wr(ADDR_CFG, 8'hD8);
        wr(ADDR_INT_CTRL, 8'h03);
        smp(14'h0200, 14'h0000, 14'h0000);
        smp(14'h0000, 14'h0200, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        `CHK("int1", 1'b1, int1_out);
        `CHK("int2", 1'b0, int2_out);
        wr(ADDR_INT_CTRL, 8'h01);
        #1;
        `CHK("int2", 1'b1, int2_out);
        `CHK("int1", 1'b0, int1_out);
        wr(ADDR_INT_CTRL, 8'h00);
        #1;
        `CHK("int2", 1'b0, int2_out);
        rchk("src", ADDR_SRC, 8'h82);
        `CHK("ea", 1'b0, event_active_out);
        smp(14'h0000, 14'h0200, 14'h0000);
        rchk("src", ADDR_SRC, 8'h88);
        wr(ADDR_CFG, 8'h00);
        $display("test latch done");
    endtask

    // x threshold 256 from msb 0x04 and lsb 0x00
    task automatic t_axis_thr();
        wr(ADDR_THR_BASE, 8'h84);
        wr(8'h74, 8'h00);
        wr(ADDR_CFG, 8'h48);
        smp(14'd514, 14'h0000, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        smp(14'd513, 14'h0000, 14'h0000);
        `CHK("ea", 1'b0, event_active_out);
        wr(ADDR_THR_BASE, 8'h04);
        smp(14'd513, 14'h0000, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        wr(ADDR_THR_BASE, 8'h00);
        $display("test axis threshold done");
    endtask

    // pattern high high low high high, then one more high
    task automatic t_debounce();
        logic [4:0] pat;
        pat = 5'b11011;
        wr(ADDR_COUNT, 8'h03);
        wr(ADDR_THS, 8'h81);
        for (int i = 4; i >= 0; i--) begin
            smp(pat[i] ? 14'h0200 : 14'h0000, 14'h0000, 14'h0000);
        end
        `CHK("ea", 1'b0, event_active_out);
        wr(ADDR_THS, 8'h01);
        repeat (3) smp(14'h0000, 14'h0000, 14'h0000);
        for (int i = 4; i >= 0; i--) begin
            smp(pat[i] ? 14'h0200 : 14'h0000, 14'h0000, 14'h0000);
        end
        `CHK("ea", 1'b1, event_active_out);
        smp(14'h0200, 14'h0000, 14'h0000);
        `CHK("ea", 1'b1, event_active_out);
        $display("test debounce done");
    endtask

    // reset in mid-run with the flag up
    task automatic t_mid_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        #1;
        `CHK("ea", 1'b0, event_active_out);
        @(posedge clk_in);
        rst_in <= 1'b0;
        rchk("src", ADDR_SRC, 8'h00);
        rchk("count", ADDR_COUNT, 8'h00);
        $display("test mid reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_mismatch      = 0;
        check_count     = 0;
        rst_in          = 1'b1;
        addr_in         = 8'h00;
        wdata_in        = 8'h00;
        wr_in           = 1'b0;
        rd_in           = 1'b0;
        sample_valid_in = 1'b0;
        accel_x_in      = '0;
        accel_y_in      = '0;
        accel_z_in      = '0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_regs();
        t_motion();
        t_freefall();
        t_latch();
        t_axis_thr();
        t_debounce();
        t_mid_reset();
        finish_test();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("Error watchdog expected done seen timeout");
        finish_test();
    end
endmodule
`default_nettype wire
